//--- hw/ddrc_buf.v
// burst data buffer: 8 words of 32 bits, registered read port
`timescale 1ns/10ps
module ddrc_buf (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        we,
   input  wire [2:0]  waddr,
   input  wire [31:0] wdata,
   input  wire [2:0]  raddr,
   output reg  [31:0] rdata
);
   reg [31:0] mem [0:7];

   // storage has no reset, only the read register does
   always @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule // ddrc_buf

//--- hw/ddrc_host.v
// ddr sdram host controller: apb register slave, command sequencer, strobe data paths
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "ddrc_regs.vh"
module ddrc_host (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         ddr_clk,
   output reg         ddr_clk_n,
   output reg         cke,
   output reg         cs_n,
   output reg         ras_n,
   output reg         cas_n,
   output reg         we_n,
   output reg  [1:0]  bank_select,
   output reg  [10:0] address_in,
   output reg  [31:0] data_io_o,
   output reg         data_io_oe,
   input  wire [31:0] data_io_i,
   output reg  [3:0]  byte_write_mask,
   output reg         strobe_o,
   output reg         strobe_oe,
   input  wire        strobe_i
);
   localparam ST_IDLE  = 5'h01;
   localparam ST_CMD   = 5'h02;
   localparam ST_WDATA = 5'h04;
   localparam ST_RWAIT = 5'h08;
   localparam ST_CLOSE = 5'h10;
   // wait counts kept 32 bits wide, only the low byte feeds close_reg or ref_cnt_reg
   localparam [31:0] ROW_CLOSE_W = `DDRC_ROW_CLOSE_CYC;
   localparam [31:0] RFC_W       = `DDRC_RFC_CYC;
   localparam [31:0] REF_W       = `DDRC_REF_CYC;

   reg  [4:0]  state_reg;
   reg  [1:0]  ph_reg;
   reg  [2:0]  op_reg;
   reg         auto_reg;
   reg         allb_reg;
   reg         go_reg;
   reg         done_reg;
   reg  [13:0] addr_reg;
   reg  [5:0]  cfg_reg;
   reg  [3:0]  mask_reg;
   reg  [2:0]  idx_reg;
   reg  [3:0]  beat_reg;
   reg  [3:0]  edge_reg;
   reg  [3:0]  cap_reg;
   reg  [3:0]  rwait_reg;
   reg  [7:0]  close_reg;
   reg  [7:0]  ref_cnt_reg;
   reg         ref_pend_reg;
   reg         ref_run_reg;
   reg         s1_reg;
   reg         s2_reg;
   reg         s3_reg;
   reg  [31:0] d1_reg;
   reg  [31:0] d2_reg;
   reg         edge_d_reg;
   wire [31:0] buf_q;
   wire        busy;
   wire        acc;
   wire        fire;
   wire        wr_fire;
   wire        mapped;
   wire        refuse;
   wire        tick;
   wire        rise;
   wire        issue_ref;
   wire        cap_we;
   wire [3:0]  beats;
   wire [3:0]  rd_limit;
   wire [2:0]  buf_raddr;
   wire [2:0]  buf_waddr;
   wire [31:0] buf_wdata;
   wire        buf_we;
   reg  [2:0]  rcw;
   reg  [31:0] rd_mux;

   assign busy    = (state_reg != ST_IDLE) | go_reg;
   assign acc     = psel & penable & ~pready;
   assign fire    = psel & penable & pready;
   assign wr_fire = fire & pwrite;
   assign mapped  = (paddr <= `DDRC_OFS_STATUS) & (paddr[1:0] == 2'b00);
   // command and buffer access would corrupt a running burst
   assign refuse  = busy & pwrite & ((paddr == `DDRC_OFS_CTRL) | (paddr == `DDRC_OFS_BUFDATA));
   // tick: falling link edge, commands change with the fall so the device sees them stable at the next rise
   assign tick    = (ph_reg == 2'd1);
   assign rise    = (ph_reg == 2'd3);
   assign issue_ref = (state_reg == ST_IDLE) & ref_pend_reg & tick;
   assign beats   = (cfg_reg[`DDRC_CFG_BL_MSB:`DDRC_CFG_BL_LSB] == 2'd0) ? 4'd2 :
                    (4'd1 << cfg_reg[`DDRC_CFG_BL_MSB:`DDRC_CFG_BL_LSB]);
   assign rd_limit = (cfg_reg[`DDRC_CFG_LAT4] ? 4'd4 : 4'd3) + {1'b0, beats[3:1]} + 4'd`DDRC_RD_SLACK;
   assign cap_we  = (state_reg == ST_RWAIT) & edge_d_reg & (cap_reg < beats);
   assign buf_we  = cap_we | (wr_fire & (paddr == `DDRC_OFS_BUFDATA) & ~busy);
   assign buf_waddr = cap_we ? cap_reg[2:0] : idx_reg;
   assign buf_wdata = cap_we ? d2_reg : pwdata;
   // read port registered: point at beat 0 already during the command cycle
   assign buf_raddr = ((state_reg == ST_WDATA) | (state_reg == ST_CMD)) ? beat_reg[2:0] : idx_reg;

   ddrc_buf u_buf (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (buf_we),
      .waddr   (buf_waddr),
      .wdata   (buf_wdata),
      .raddr   (buf_raddr),
      .rdata   (buf_q)
   );

   always @* begin
      case (op_reg)
         `DDRC_OP_ACT:   rcw = `DDRC_RCW_ACT;
         `DDRC_OP_READ:  rcw = `DDRC_RCW_READ;
         `DDRC_OP_WRITE: rcw = `DDRC_RCW_WRITE;
         `DDRC_OP_PRE:   rcw = `DDRC_RCW_PRE;
         `DDRC_OP_REF:   rcw = `DDRC_RCW_REF;
         `DDRC_OP_MRS:   rcw = `DDRC_RCW_MRS;
         default:        rcw = `DDRC_RCW_NOP;
      endcase
   end

   always @* begin
      case (paddr)
         `DDRC_OFS_CTRL:    rd_mux = {27'h0, allb_reg, auto_reg, op_reg};
         `DDRC_OFS_ADDR:    rd_mux = {18'h0, addr_reg};
         `DDRC_OFS_CFG:     rd_mux = {26'h0, cfg_reg};
         `DDRC_OFS_MASK:    rd_mux = {28'h0, mask_reg};
         `DDRC_OFS_BUFIDX:  rd_mux = {29'h0, idx_reg};
         `DDRC_OFS_BUFDATA: rd_mux = busy ? 32'h0000_0000 : buf_q;
         `DDRC_OFS_STATUS:  rd_mux = {25'h0, cap_reg, ref_pend_reg, done_reg, busy};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   // apb slave: one wait state, effect at the edge that samples pready
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0000_0000;
         addr_reg <= 14'h0000;
         cfg_reg  <= `DDRC_CFG_RESET;
         mask_reg <= `DDRC_MASK_RESET;
         idx_reg  <= 3'h0;
      end else begin
         pready  <= acc;
         pslverr <= acc & (~mapped | refuse | (busy & ~pwrite & (paddr == `DDRC_OFS_BUFDATA)));
         if (acc) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
         if (wr_fire & (paddr == `DDRC_OFS_ADDR)) begin
            addr_reg <= {pwdata[`DDRC_ADDR_BA_MSB:`DDRC_ADDR_BA_LSB], 1'b0, pwdata[`DDRC_ADDR_A_MSB:0]};
         end
         if (wr_fire & (paddr == `DDRC_OFS_CFG)) begin
            cfg_reg <= pwdata[5:0];
         end
         if (wr_fire & (paddr == `DDRC_OFS_MASK)) begin
            mask_reg <= pwdata[3:0];
         end
         if (wr_fire & (paddr == `DDRC_OFS_BUFIDX)) begin
            idx_reg <= pwdata[2:0];
         end
      end
   end

   // link clock divider: four pclk per link cycle, high in phases 0 and 1
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // start in a low phase so the first high half is full width
         ph_reg    <= 2'd3;
         ddr_clk   <= 1'b0;
         ddr_clk_n <= 1'b1;
         cke       <= 1'b0;
      end else begin
         ph_reg    <= ph_reg + 2'd1;
         ddr_clk   <= (ph_reg == 2'd3) | (ph_reg == 2'd0);
         ddr_clk_n <= ~((ph_reg == 2'd3) | (ph_reg == 2'd0));
         if (tick) begin
            cke <= cfg_reg[`DDRC_CFG_CKE];
         end
      end
   end

   // refresh pacing; set wins over the clear from the sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt_reg  <= 8'd0;
         ref_pend_reg <= 1'b0;
      end else if (!cfg_reg[`DDRC_CFG_REFEN]) begin
         ref_cnt_reg  <= 8'd0;
         ref_pend_reg <= 1'b0;
      end else if (ref_cnt_reg == 8'd0) begin
         ref_cnt_reg  <= REF_W[7:0] - 8'd1;
         ref_pend_reg <= 1'b1;
      end else begin
         ref_cnt_reg  <= ref_cnt_reg - 8'd1;
         if (issue_ref) begin
            ref_pend_reg <= 1'b0;
         end
      end
   end

   // read strobe and data cross into pclk before use
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg     <= 1'b0;
         s2_reg     <= 1'b0;
         s3_reg     <= 1'b0;
         d1_reg     <= 32'h0000_0000;
         d2_reg     <= 32'h0000_0000;
         edge_d_reg <= 1'b0;
      end else begin
         s1_reg     <= strobe_i;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         d1_reg     <= data_io_i;
         d2_reg     <= d1_reg;
         // data edge-aligned: take it one pclk after the strobe edge, mid-beat
         edge_d_reg <= s2_reg ^ s3_reg;
      end
   end

   // command sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg       <= ST_IDLE;
         op_reg          <= `DDRC_OP_NOP;
         auto_reg        <= 1'b0;
         allb_reg        <= 1'b0;
         go_reg          <= 1'b0;
         done_reg        <= 1'b0;
         beat_reg        <= 4'd0;
         edge_reg        <= 4'd0;
         cap_reg         <= 4'd0;
         rwait_reg       <= 4'd0;
         close_reg       <= 8'd0;
         ref_run_reg     <= 1'b0;
         cs_n            <= 1'b1;
         ras_n           <= 1'b1;
         cas_n           <= 1'b1;
         we_n            <= 1'b1;
         bank_select     <= 2'b00;
         address_in      <= 11'h000;
         data_io_o       <= 32'h0000_0000;
         data_io_oe      <= 1'b0;
         byte_write_mask <= 4'hf;
         strobe_o        <= 1'b0;
         strobe_oe       <= 1'b0;
      end else begin
         if (wr_fire & (paddr == `DDRC_OFS_CTRL) & ~busy) begin
            op_reg   <= pwdata[`DDRC_CTRL_OP_MSB:`DDRC_CTRL_OP_LSB];
            auto_reg <= pwdata[`DDRC_CTRL_AUTO];
            allb_reg <= pwdata[`DDRC_CTRL_ALLB];
            go_reg   <= 1'b1;
         end
         if (wr_fire & (paddr == `DDRC_OFS_STATUS) & pwdata[`DDRC_ST_DONE]) begin
            done_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               if (issue_ref) begin
                  {ras_n, cas_n, we_n} <= `DDRC_RCW_REF;
                  cs_n      <= 1'b0;
                  close_reg <= RFC_W[7:0];
                  // own flag: op_reg still holds the last software command
                  ref_run_reg <= 1'b1;
                  state_reg <= ST_CMD;
               end else if (go_reg & tick) begin
                  go_reg      <= 1'b0;
                  ref_run_reg <= 1'b0;
                  cs_n        <= 1'b0;
                  {ras_n, cas_n, we_n} <= rcw;
                  bank_select <= addr_reg[13:12];
                  beat_reg    <= 4'd0;
                  edge_reg    <= 4'd0;
                  cap_reg     <= 4'd0;
                  rwait_reg   <= 4'd0;
                  close_reg   <= 8'd1;
                  case (op_reg)
                     `DDRC_OP_READ, `DDRC_OP_WRITE: begin
                        // auto close on A8, column on A7..A0; without it the row stays open
                        address_in <= {2'b00, auto_reg, addr_reg[7:0]};
                        if (auto_reg) begin
                           close_reg <= ROW_CLOSE_W[7:0];
                        end
                     end
                     `DDRC_OP_PRE: begin
                        address_in <= {allb_reg, 10'h000};
                        close_reg  <= ROW_CLOSE_W[7:0];
                     end
                     default: begin
                        address_in <= addr_reg[10:0];
                     end
                  endcase
                  state_reg <= ST_CMD;
               end
            end
            ST_CMD: begin
               // command held across one rising edge, then decoder disabled
               if (tick) begin
                  cs_n <= 1'b1;
                  {ras_n, cas_n, we_n} <= `DDRC_RCW_NOP;
                  if ((op_reg == `DDRC_OP_WRITE) & ~ref_run_reg) begin
                     strobe_oe <= 1'b1;
                     strobe_o  <= 1'b0;
                     state_reg <= ST_WDATA;
                  end else if ((op_reg == `DDRC_OP_READ) & ~ref_run_reg) begin
                     state_reg <= ST_RWAIT;
                  end else begin
                     state_reg <= ST_CLOSE;
                  end
               end
            end
            ST_WDATA: begin
               // data changes at phases 2/0, strobe at 3/1: strobe centred in each beat
               if (((ph_reg == 2'd2) | (ph_reg == 2'd0)) & (beat_reg < beats)) begin
                  data_io_o       <= buf_q;
                  data_io_oe      <= 1'b1;
                  byte_write_mask <= mask_reg;
                  beat_reg        <= beat_reg + 4'd1;
               end
               if ((rise | tick) & (edge_reg < beats)) begin
                  strobe_o <= ~strobe_o;
                  edge_reg <= edge_reg + 4'd1;
               end else if (rise & (edge_reg == beats)) begin
                  strobe_oe       <= 1'b0;
                  data_io_oe      <= 1'b0;
                  byte_write_mask <= 4'hf;
                  state_reg       <= ST_CLOSE;
               end
            end
            ST_RWAIT: begin
               if (cap_we) begin
                  cap_reg <= cap_reg + 4'd1;
               end
               if (rise) begin
                  rwait_reg <= rwait_reg + 4'd1;
               end
               // bank closes latency cycles after last data, so wait those out too
               if ((cap_reg == beats) | (rwait_reg == rd_limit)) begin
                  if (auto_reg) begin
                     close_reg <= ROW_CLOSE_W[7:0] + (cfg_reg[`DDRC_CFG_LAT4] ? 8'd16 : 8'd12);
                  end
                  state_reg <= ST_CLOSE;
               end
            end
            ST_CLOSE: begin
               if (close_reg <= 8'd1) begin
                  if (~ref_run_reg) begin
                     done_reg <= 1'b1;
                  end
                  state_reg <= ST_IDLE;
               end else begin
                  close_reg <= close_reg - 8'd1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // ddrc_host

//--- pkg/ddrc_regs.vh
// register map, field positions, reset values and timing counts of the ddr host controller
`ifndef DDRC_REGS_VH
`define DDRC_REGS_VH
`define DDRC_OFS_CTRL      8'h00
`define DDRC_OFS_ADDR      8'h04
`define DDRC_OFS_CFG       8'h08
`define DDRC_OFS_MASK      8'h0c
`define DDRC_OFS_BUFIDX    8'h10
`define DDRC_OFS_BUFDATA   8'h14
`define DDRC_OFS_STATUS    8'h18
`define DDRC_CTRL_OP_LSB   0
`define DDRC_CTRL_OP_MSB   2
`define DDRC_CTRL_AUTO     3
`define DDRC_CTRL_ALLB     4
`define DDRC_ADDR_A_MSB    10
`define DDRC_ADDR_BA_LSB   12
`define DDRC_ADDR_BA_MSB   13
`define DDRC_CFG_LAT4      0
`define DDRC_CFG_BL_LSB    1
`define DDRC_CFG_BL_MSB    2
`define DDRC_CFG_CKE       4
`define DDRC_CFG_REFEN     5
`define DDRC_CFG_RESET     6'h02
`define DDRC_MASK_RESET    4'h0
`define DDRC_ST_BUSY       0
`define DDRC_ST_DONE       1
`define DDRC_ST_REFP       2
`define DDRC_ST_CAP_LSB    3
`define DDRC_OP_NOP        3'h0
`define DDRC_OP_ACT        3'h1
`define DDRC_OP_READ       3'h2
`define DDRC_OP_WRITE      3'h3
`define DDRC_OP_PRE        3'h4
`define DDRC_OP_REF        3'h5
`define DDRC_OP_MRS        3'h6
`define DDRC_RCW_NOP       3'h7
`define DDRC_RCW_ACT       3'h3
`define DDRC_RCW_READ      3'h5
`define DDRC_RCW_WRITE     3'h4
`define DDRC_RCW_PRE       3'h2
`define DDRC_RCW_REF       3'h1
`define DDRC_RCW_MRS       3'h0
`define DDRC_AUTO_BIT      8
`define DDRC_ALLB_BIT      10
`define DDRC_PCLK_MHZ      20
`define DDRC_ROW_CLOSE_NS  20
`define DDRC_ROW_CLOSE_CYC ((`DDRC_ROW_CLOSE_NS * `DDRC_PCLK_MHZ + 999) / 1000)
`define DDRC_RFC_NS        70
`define DDRC_RFC_CYC       ((`DDRC_RFC_NS * `DDRC_PCLK_MHZ + 999) / 1000)
`define DDRC_REF_WIN_US    16000
`define DDRC_REF_ROWS      2048
`define DDRC_REF_CYC       ((`DDRC_REF_WIN_US * `DDRC_PCLK_MHZ) / `DDRC_REF_ROWS)
`define DDRC_RD_SLACK      3
`endif

//--- testbench/ddrc_host_checker.sv
// port assertions for the ddr host controller
`timescale 1ns/10ps
module ddrc_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        ddr_clk,
   input wire logic        ddr_clk_n,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [1:0]  bank_select,
   input wire logic [10:0] address_in,
   input wire logic [31:0] data_io_o,
   input wire logic        data_io_oe,
   input wire logic [3:0]  byte_write_mask,
   input wire logic        strobe_o,
   input wire logic        strobe_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_clk_pair; ddr_clk_n == !ddr_clk; endproperty
   a_clk_pair: assert property (p_clk_pair) else $error("link clock pair not complementary");
   property p_clk_period; $rose(ddr_clk) |-> ddr_clk ##1 ddr_clk ##1 !ddr_clk ##1 !ddr_clk ##1 ddr_clk; endproperty
   a_clk_period: assert property (p_clk_period) else $error("link clock period wrong");
   property p_cmd_at_fall;
      $changed({cs_n, ras_n, cas_n, we_n, bank_select, address_in}) |-> $fell(ddr_clk);
   endproperty
   a_cmd_at_fall: assert property (p_cmd_at_fall) else $error("command pins moved off link fall");
   property p_cs_pulse; $fell(cs_n) |-> !cs_n [*4] ##1 cs_n; endproperty
   a_cs_pulse: assert property (p_cs_pulse) else $error("select not one link cycle");
   property p_code; !cs_n |-> {ras_n, cas_n, we_n} != 3'h6; endproperty
   a_code: assert property (p_code) else $error("illegal strobe code");
   property p_mask_hold; data_io_oe && $past(data_io_oe) |-> $stable(byte_write_mask); endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("mask moved within burst");
   property p_centred; strobe_oe && $changed(strobe_o) |-> data_io_oe && $stable(data_io_o); endproperty
   a_centred: assert property (p_centred) else $error("strobe edge not centred");
   property p_preamble; $rose(strobe_oe) |-> !strobe_o ##1 data_io_oe; endproperty
   a_preamble: assert property (p_preamble) else $error("write preamble wrong");
   property p_data_strobe; data_io_oe |-> strobe_oe; endproperty
   a_data_strobe: assert property (p_data_strobe) else $error("data driven without strobe");
   property p_apb_wait; psel && penable && !pready |=> pready && psel && penable; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
   c_write: cover property (!cs_n && {ras_n, cas_n, we_n} == 3'h4);
   c_read: cover property (!cs_n && {ras_n, cas_n, we_n} == 3'h5);
   c_pre_all: cover property (!cs_n && {ras_n, cas_n, we_n} == 3'h2 && address_in[10]);
endmodule // ddrc_chk
bind ddrc_host ddrc_chk chk_u (.pclk, .presetn, .psel, .penable, .pready, .ddr_clk, .ddr_clk_n, .cs_n, .ras_n,
   .cas_n, .we_n, .bank_select, .address_in, .data_io_o, .data_io_oe, .byte_write_mask, .strobe_o, .strobe_oe);

//--- testbench/ddrc_host_tb.sv
// self-checking bench for the ddr host controller
`timescale 1ns/10ps
`include "ddrc_regs.vh"
module ddrc_host_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, d, data_io_o, data_io_i, mdl_dq;
   logic        ddr_clk, ddr_clk_n, cke, cs_n, ras_n, cas_n, we_n;
   logic        data_io_oe, strobe_o, strobe_oe, strobe_i, mdl_dqs, ap;
   logic [1:0]  bank_select, b;
   logic [10:0] address_in, row;
   logic [7:0]  col;
   logic [3:0]  byte_write_mask, mk;
   int          viol, refs, miscompares, checked, bl, kb;
   logic [31:0] ref_mem [int];
   ddrc_host dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ddr_clk, .ddr_clk_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .address_in, .data_io_o,
      .data_io_oe, .data_io_i, .byte_write_mask, .strobe_o, .strobe_oe, .strobe_i);
   ddrc_mem_model mdl_u (.ddr_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .address_in, .data_io_o,
      .data_io_oe, .byte_write_mask, .strobe_o, .strobe_oe, .dq(mdl_dq), .dqs(mdl_dqs), .viol, .refs);
   // shared wires: whoever enables drives
   assign data_io_i = data_io_oe ? data_io_o : mdl_dq;
   assign strobe_i = strobe_oe ? strobe_o : mdl_dqs;
   initial begin pclk = 0; forever #25 pclk = ~pclk; end
   task stop_test;
      if (miscompares == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin $display("[FAIL] %s expected %h seen %h", n, x, g); miscompares++; end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1);
      q = prdata; e = pslverr;
      psel <= 0; penable <= 0;
      chk("apb_wait", 2, n);
   endtask
   // one command, waits for done then clears it
   task cmd(input logic [2:0] op, input logic a8, input logic allb, input logic [1:0] bk, input logic [10:0] a);
      int n;
      apb(1, `DDRC_OFS_ADDR, {18'h0, bk, 1'b0, a});
      apb(1, `DDRC_OFS_CTRL, {27'h0, allb, a8, op});
      if (op == `DDRC_OP_WRITE) begin apb(1, `DDRC_OFS_CTRL, 0); chk("busy_refuse", 1, e); end
      n = 0;
      do begin apb(0, `DDRC_OFS_STATUS, 0); n++; end while (q[1] !== 1'b1 && n < 200);
      chk("done", 1, q[1]);
      apb(1, `DDRC_OFS_STATUS, 32'h2);
   endtask
   initial begin
      #1000000;
      chk("watchdog", 0, 1);
      stop_test;
   end
   initial begin
      void'($urandom(32'h89c04469));
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(0, `DDRC_OFS_CFG, 0); chk("cfg_reset", 32'h2, q);
      apb(0, `DDRC_OFS_MASK, 0); chk("mask_reset", 0, q);
      apb(0, 8'h1c, 0); chk("unmapped_err", 1, e); chk("unmapped_data", 0, q);
      apb(1, `DDRC_OFS_CFG, 0); repeat (10) @(posedge pclk); chk("cke_low", 0, cke);
      for (int lt = 3; lt <= 4; lt++) for (int bc = 1; bc <= 3; bc++) begin
         bl = 1 << bc;
         apb(1, `DDRC_OFS_CFG, 32'h10 | (bc << 1) | (lt - 3));
         repeat (10) @(posedge pclk); chk("cke_high", 1, cke);
         cmd(`DDRC_OP_MRS, 0, 0, 0, 11'((lt << 4) | bc));
         b = 2'($urandom); row = 11'($urandom); col = 8'($urandom) & 8'(256 - bl); ap = 1'($urandom);
         kb = int'({b, row, col});
         cmd(`DDRC_OP_ACT, 0, 0, b, row);
         cmd(`DDRC_OP_ACT, 0, 0, b ^ 2'h1, ~row);
         // first pass fills every byte, second one masks at random
         for (int m = 0; m < 2; m++) begin
            mk = m ? 4'($urandom) : 4'h0;
            apb(1, `DDRC_OFS_MASK, {28'h0, mk});
            for (int k = 0; k < bl; k++) begin
               d = $urandom;
               apb(1, `DDRC_OFS_BUFIDX, k);
               apb(1, `DDRC_OFS_BUFDATA, d);
               for (int j = 0; j < 4; j++) if (!mk[j]) ref_mem[kb+k][j*8+:8] = d[j*8+:8];
            end
            cmd(`DDRC_OP_WRITE, 0, 0, b, {3'h0, col});
         end
         cmd(`DDRC_OP_READ, ap, 0, b, {3'h0, col});
         apb(0, `DDRC_OFS_STATUS, 0); chk("beats", bl, {28'h0, q[6:3]});
         for (int k = 0; k < bl; k++) begin
            apb(1, `DDRC_OFS_BUFIDX, k);
            apb(0, `DDRC_OFS_BUFDATA, 0); chk("read_word", ref_mem[kb+k], q);
         end
         if (ap) cmd(`DDRC_OP_PRE, 0, 0, b ^ 2'h1, 0);
         else cmd(`DDRC_OP_PRE, 0, 1, 2'($urandom), 0);
         chk("bank_use", 0, viol);
      end
      apb(1, `DDRC_OFS_CFG, 32'h32);
      repeat (400) @(posedge pclk);
      apb(1, `DDRC_OFS_CFG, 32'h02);
      repeat (20) @(posedge pclk);
      chk("cke_off", 0, cke);
      chk("refresh_count", 1, refs >= 2 && refs <= 3);
      chk("refresh_use", 0, viol);
      stop_test;
   end
endmodule // ddrc_host_tb

//--- testbench/ddrc_mem_model.sv
// behavioural ddr memory device on the far side of the host
`timescale 1ns/10ps
module ddrc_mem_model (
   input wire logic         ddr_clk,
   input wire logic         cke,
   input wire logic         cs_n,
   input wire logic         ras_n,
   input wire logic         cas_n,
   input wire logic         we_n,
   input wire logic [1:0]   bank_select,
   input wire logic [10:0]  address_in,
   input wire logic [31:0]  data_io_o,
   input wire logic         data_io_oe,
   input wire logic [3:0]   byte_write_mask,
   input wire logic         strobe_o,
   input wire logic         strobe_oe,
   output logic     [31:0]  dq,
   output logic             dqs,
   output int               viol,
   output int               refs
);
   logic [31:0] mem [int];
   logic [10:0] row_of [4];
   logic [3:0]  open_b;
   logic        rd_on, rap, wap;
   logic [1:0]  rbank, wbank;
   int          bl, lat, hc, rbase, wbase, wbeat;
   initial begin
      dq = 0; dqs = 0; viol = 0; refs = 0; open_b = 0; rd_on = 0; bl = 2; lat = 3; wbeat = 99;
   end
   function int key(input logic [1:0] b, input logic [7:0] c);
      return int'({b, row_of[b], c});
   endfunction
   // strobe rests low, as if terminated, so the first read edge is a clean rise
   always @(posedge ddr_clk or negedge ddr_clk) begin
      if (rd_on) begin
         hc++;
         if (hc >= 2*lat && hc < 2*lat+bl) begin dq = mem[rbase+hc-2*lat]; dqs = !dqs; end
         if (hc == 2*lat+bl) dq = ~dq;
         if (hc == 4*lat+bl-1) begin if (rap) open_b[rbank] = 0; rd_on = 0; end
      end
      if (ddr_clk && cke && !cs_n) case ({ras_n, cas_n, we_n})
         3'h3: begin
            if (open_b[bank_select]) viol++;
            open_b[bank_select] = 1; row_of[bank_select] = address_in;
         end
         3'h5: begin
            if (!open_b[bank_select] || rd_on) viol++;
            rbank = bank_select; rbase = key(bank_select, address_in[7:0]); rap = address_in[8];
            hc = 0; rd_on = 1;
         end
         3'h4: begin
            if (!open_b[bank_select]) viol++;
            wbank = bank_select; wbase = key(bank_select, address_in[7:0]); wap = address_in[8]; wbeat = 0;
         end
         3'h2: if (address_in[10]) open_b = 0; else open_b[bank_select] = 0;
         3'h1: begin if (open_b != 0) viol++; refs++; end
         3'h0: begin bl = 1 << address_in[2:0]; lat = int'(address_in[6:4]); end
         default: ;
      endcase
   end
   always @(posedge strobe_o or negedge strobe_o) if (strobe_oe && data_io_oe && wbeat < bl) begin
      for (int j = 0; j < 4; j++) if (!byte_write_mask[j]) mem[wbase+wbeat][j*8+:8] = data_io_o[j*8+:8];
      wbeat++;
      if (wbeat == bl && wap) open_b[wbank] = 0;
   end
endmodule // ddrc_mem_model
